// File: core/psfs_pkg.sv
// Purpose: constants for the pid set point / feedback conditioning block
// Assumes: 16-bit parameters in fixed point units (0.1 %, 0.01 s, 1 ms, 0.01, 0.1)
// Notes:   register index = printed offset, byte address = index * 4
package psfs_pkg;
  // ==========================================================================
  // register indices
  localparam logic [13:0] IDX_SP_SEL   = 14'h0d00;
  localparam logic [13:0] IDX_KP       = 14'h0d01;
  localparam logic [13:0] IDX_RAMP     = 14'h0d02;
  localparam logic [13:0] IDX_FB_SEL   = 14'h0d03;
  localparam logic [13:0] IDX_FILT     = 14'h0d04;
  localparam logic [13:0] IDX_GAIN     = 14'h0d05;
  localparam logic [13:0] IDX_RANGE    = 14'h0d06;
  localparam logic [13:0] IDX_SHORTCUT = 14'h0d10;
  localparam logic [13:0] IDX_SP_MON   = 14'h0d11;
  localparam logic [13:0] IDX_FB_MON   = 14'h0d12;
  localparam logic [13:0] IDX_DISP_MON = 14'h0d13;
  localparam logic [13:0] IDX_ACT_COMM = 14'h3011;
  // ==========================================================================
  // reset values and limits
  localparam logic [15:0] RST_SP_SEL = 16'h0000;
  localparam logic [15:0] RST_KP     = 16'h01f4;
  localparam logic [15:0] RST_RAMP   = 16'h0064;
  localparam logic [15:0] RST_FB_SEL = 16'h0002;
  localparam logic [15:0] RST_FILT   = 16'h000a;
  localparam logic [15:0] RST_GAIN   = 16'h0064;
  localparam logic [15:0] RST_RANGE  = 16'h03e8;
  localparam logic [15:0] MAX_SEL    = 16'h0009;
  localparam logic [15:0] MAX_PCT    = 16'h03e8;
  localparam logic [15:0] MAX_RAMP   = 16'h1770;
  localparam logic [15:0] MAX_FILT   = 16'h1770;
  localparam logic [15:0] MAX_GAIN   = 16'h03e8;
  localparam logic [15:0] MAX_RANGE  = 16'h03e8;
  localparam int          GAIN_UNITY = 100;
  localparam int          RANGE_FULL = 1000;
  // ==========================================================================
  // source codes and shortcut digits
  localparam logic [3:0] SRC_KEYPAD   = 4'h0;
  localparam logic [3:0] SRC_TERMINAL = 4'h8;
  localparam logic [3:0] SRC_ACTIVE   = 4'h9;
  localparam logic [3:0] SHORT_KEYS   = 4'h2;
  localparam logic [3:0] SHORT_RETAIN = 4'h1;
  // ==========================================================================
  // timing
  localparam int CLK_NS      = 50;
  localparam int TICK_NS     = 1000000;
  localparam int TICK_CYC    = TICK_NS / CLK_NS;
  localparam int RAMP_UNIT_NS = 10000;
  localparam int RAMP_CYC    = RAMP_UNIT_NS / CLK_NS;
  localparam int DIV_STEPS   = 17;
endpackage : psfs_pkg

// File: core/psfs_top.sv
// Purpose: pid set point and feedback source selection, ramp, filter, gain
// Assumes: all inputs synchronous to ref_clk, sources in 0.1 % units
// Notes:   avalon-mm slave with one wait state on every access
//
// Summary of operation
// - set point source chosen by codes 0 to 9, reset selects keypad.
// - code 0 takes set point from stored keypad percentage.
// - codes 2,3,6,5,7 take ain1, ain2, rs485, pulse, option card.
// - code 8 picks set point source from three assigned terminals.
// - terminals form binary code, terminal 3 msb, 0..7 select channels.
// - code 9 uses active current written over communication at 0x3011.
// - keypad percentage, reset 50.0 %, acts only where selected.
// - writing keypad percentage updates monitored set point at once.
// - shortcut digit 2 lets up/down keys adjust keypad; next digit retains.
// - set point ramps linearly, full swing takes configured ramp time.
// - feedback source chosen by codes 0 to 9, reset 2 selects ain1.
// - feedback code 0 takes stored keypad percentage.
// - feedback codes 2,3,5,6,7 take ain1, ain2, pulse, rs485, option.
// - feedback code 8 picks channel from three assigned terminals.
// - terminal code 0..7 selects the same channel order for feedback.
// - feedback code 9 uses locally measured active current.
// - feedback low-pass filtered with configurable time constant.
// - feedback multiplied by gain 0.00 to 10.00, reset 1.00.
// - display range scales only the displayed feedback.
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
module psfs_top import psfs_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] analog_input_one,
  input  wire logic [15:0] analog_input_two,
  input  wire logic [15:0] pot_value,
  input  wire logic [15:0] pulse_input_terminal,
  input  wire logic [15:0] rs485_value,
  input  wire logic [15:0] option_card_value,
  input  wire logic [15:0] local_active_current,
  input  wire logic [2:0]  select_terminals,
  input  wire logic        key_up,
  input  wire logic        key_down,
  output logic      [15:0] pid_setpoint,
  output logic      [15:0] pid_feedback,
  output logic      [15:0] feedback_display,
  output logic             keypad_retain
);
  // ==========================================================================
  // elaboration check
  localparam int TW = $clog2(TICK_CYCLES);
  if (TICK_CYCLES < 2 * DIV_STEPS) begin : g_chk
    $error("TICK_CYCLES too small for coefficient divider");
  end

  typedef struct packed {
    logic [15:0] sp_sel;
    logic [15:0] kp;
    logic [15:0] ramp;
    logic [15:0] fb_sel;
    logic [15:0] filt;
    logic [15:0] gain;
    logic [15:0] range;
    logic [15:0] shortcut;
    logic [15:0] act_comm;
    logic [15:0] sp_out;
    logic [20:0] ramp_cnt;
    logic [TW-1:0] tick_cnt;
    logic        tick;
    logic [31:0] y_q;
    logic [16:0] alpha;
    logic [16:0] div_rem;
    logic [16:0] div_quo;
    logic [4:0]  div_cnt;
    logic [15:0] disp;
    logic [31:0] rdata;
    logic        waitreq;
    logic        retain;
  } psfs_state_t;

  psfs_state_t r;
  psfs_state_t next_r;

  // ==========================================================================
  // source selection
  logic [15:0] src_val [0:7];
  logic [2:0]  sp_idx;
  logic [2:0]  fb_idx;
  logic [15:0] sp_raw;
  logic [15:0] fb_raw;
  logic [15:0] fb_gained;
  logic [31:0] gain_prod;

  always_comb begin
    src_val[0] = r.kp;
    src_val[1] = pot_value;
    src_val[2] = analog_input_one;
    src_val[3] = analog_input_two;
    src_val[4] = 16'h0000;
    src_val[5] = pulse_input_terminal;
    src_val[6] = rs485_value;
    src_val[7] = option_card_value;
    // terminal 3 is the msb of the code
    sp_idx = (r.sp_sel[3:0] == SRC_TERMINAL) ? select_terminals : r.sp_sel[2:0];
    fb_idx = (r.fb_sel[3:0] == SRC_TERMINAL) ? select_terminals : r.fb_sel[2:0];
    sp_raw = (r.sp_sel[3:0] == SRC_ACTIVE) ? r.act_comm : src_val[sp_idx];
    fb_raw = (r.fb_sel[3:0] == SRC_ACTIVE) ? local_active_current
                                           : src_val[fb_idx];
    gain_prod = 32'(fb_raw) * 32'(r.gain) / 32'(GAIN_UNITY);
    fb_gained = (gain_prod[31:16] != 16'h0000) ? 16'hffff : gain_prod[15:0];
  end

  // ==========================================================================
  // register access
  logic        acc;
  logic        wr_go;
  logic [13:0] idx;
  logic        aligned;

  function automatic logic [15:0] merge(input logic [15:0] o);
    merge = {avs_byteenable[1] ? avs_writedata[15:8] : o[15:8],
             avs_byteenable[0] ? avs_writedata[7:0]  : o[7:0]};
  endfunction : merge

  always_comb begin
    acc     = (avs_read | avs_write) & r.waitreq;
    wr_go   = avs_write & ~r.waitreq;
    idx     = avs_address[15:2];
    aligned = (avs_address[1:0] == 2'h0);
  end

  // ==========================================================================
  // next state
  logic [15:0]        wv;
  logic signed [32:0] diff;
  logic signed [50:0] prod;
  logic [16:0]        shv;
  logic [16:0]        dvs;
  logic [31:0]        disp_prod;
  logic               kp_wr;

  always_comb begin
    next_r    = r;
    wv        = 16'h0000;
    kp_wr     = 1'b0;
    diff      = '0;
    prod      = '0;
    shv       = '0;
    dvs       = 17'(r.filt) + 17'h00001;
    disp_prod = 32'(r.y_q[31:16]) * 32'(r.range) / 32'(RANGE_FULL);

    // one wait state, then a single cycle with waitrequest low
    next_r.waitreq = ~acc;
    next_r.rdata   = 32'h00000000;
    if (acc && aligned) begin
      case (idx)
        IDX_SP_SEL:   next_r.rdata = {16'h0000, r.sp_sel};
        IDX_KP:       next_r.rdata = {16'h0000, r.kp};
        IDX_RAMP:     next_r.rdata = {16'h0000, r.ramp};
        IDX_FB_SEL:   next_r.rdata = {16'h0000, r.fb_sel};
        IDX_FILT:     next_r.rdata = {16'h0000, r.filt};
        IDX_GAIN:     next_r.rdata = {16'h0000, r.gain};
        IDX_RANGE:    next_r.rdata = {16'h0000, r.range};
        IDX_SHORTCUT: next_r.rdata = {16'h0000, r.shortcut};
        IDX_SP_MON:   next_r.rdata = {16'h0000, r.sp_out};
        IDX_FB_MON:   next_r.rdata = {16'h0000, r.y_q[31:16]};
        IDX_DISP_MON: next_r.rdata = {16'h0000, r.disp};
        IDX_ACT_COMM: next_r.rdata = {16'h0000, r.act_comm};
        default:      next_r.rdata = 32'h00000000;
      endcase
    end

    // keypad shortcut keys; a bus write in the same cycle wins
    if (r.shortcut[3:0] == SHORT_KEYS) begin
      if (key_up && !key_down && r.kp < MAX_PCT) begin
        next_r.kp = r.kp + 16'h0001;
      end else if (key_down && !key_up && r.kp != 16'h0000) begin
        next_r.kp = r.kp - 16'h0001;
      end
    end
    next_r.retain = (r.shortcut[7:4] == SHORT_RETAIN);

    // out-of-range writes are refused and the old value kept
    if (wr_go && aligned) begin
      case (idx)
        IDX_SP_SEL: begin
          wv = merge(r.sp_sel);
          if (wv <= MAX_SEL) next_r.sp_sel = wv;
        end
        IDX_KP: begin
          wv = merge(r.kp);
          if (wv <= MAX_PCT) begin
            next_r.kp = wv;
            kp_wr     = 1'b1;
          end
        end
        IDX_RAMP: begin
          wv = merge(r.ramp);
          if (wv <= MAX_RAMP) next_r.ramp = wv;
        end
        IDX_FB_SEL: begin
          wv = merge(r.fb_sel);
          if (wv <= MAX_SEL) next_r.fb_sel = wv;
        end
        IDX_FILT: begin
          wv = merge(r.filt);
          if (wv <= MAX_FILT) next_r.filt = wv;
        end
        IDX_GAIN: begin
          wv = merge(r.gain);
          if (wv <= MAX_GAIN) next_r.gain = wv;
        end
        IDX_RANGE: begin
          wv = merge(r.range);
          if (wv <= MAX_RANGE) next_r.range = wv;
        end
        IDX_SHORTCUT: next_r.shortcut = merge(r.shortcut);
        IDX_ACT_COMM: next_r.act_comm = merge(r.act_comm);
        default: begin
        end
      endcase
    end

    // set point ramp: one 0.1 % step every ramp * RAMP_CYC cycles
    if (kp_wr && sp_idx == SRC_KEYPAD[2:0] && r.sp_sel[3:0] != SRC_ACTIVE) begin
      next_r.sp_out   = wv;
      next_r.ramp_cnt = 21'h000000;
    end else if (r.ramp == 16'h0000 || r.sp_out == sp_raw) begin
      next_r.sp_out   = sp_raw;
      next_r.ramp_cnt = 21'h000000;
    end else if (r.ramp_cnt >= 21'(r.ramp) * 21'(RAMP_CYC) - 21'h000001) begin
      next_r.ramp_cnt = 21'h000000;
      next_r.sp_out   = (sp_raw > r.sp_out) ? r.sp_out + 16'h0001
                                            : r.sp_out - 16'h0001;
    end else begin
      next_r.ramp_cnt = r.ramp_cnt + 21'h000001;
    end

    // control tick
    next_r.tick = 1'b0;
    if (r.tick_cnt == TW'(TICK_CYCLES - 1)) begin
      next_r.tick_cnt = '0;
      next_r.tick     = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + TW'(1);
    end

    // coefficient 65536 / (filter_ms + 1), recomputed every tick
    if (r.tick) begin
      next_r.div_cnt = 5'(DIV_STEPS);
      next_r.div_rem = 17'h00000;
      next_r.div_quo = 17'h00000;
    end else if (r.div_cnt != 5'h00) begin
      shv = {r.div_rem[15:0], r.div_cnt == 5'(DIV_STEPS)};
      if (shv >= dvs) begin
        next_r.div_rem = shv - dvs;
        next_r.div_quo = {r.div_quo[15:0], 1'b1};
      end else begin
        next_r.div_rem = shv;
        next_r.div_quo = {r.div_quo[15:0], 1'b0};
      end
      next_r.div_cnt = r.div_cnt - 5'h01;
      if (r.div_cnt == 5'h01) next_r.alpha = next_r.div_quo;
    end

    // first-order low-pass, y += (x - y) * alpha
    if (r.tick) begin
      diff = $signed({1'b0, fb_gained, 16'h0000}) - $signed({1'b0, r.y_q});
      prod = diff * $signed({1'b0, r.alpha});
      next_r.y_q = r.y_q + prod[47:16];
    end
    next_r.disp = disp_prod[15:0];
  end

  // ==========================================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      r          <= '0;
      r.sp_sel   <= RST_SP_SEL;
      r.kp       <= RST_KP;
      r.ramp     <= RST_RAMP;
      r.fb_sel   <= RST_FB_SEL;
      r.filt     <= RST_FILT;
      r.gain     <= RST_GAIN;
      r.range    <= RST_RANGE;
      r.alpha    <= 17'(65536 / (RST_FILT + 1));
      r.waitreq  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign avs_readdata     = r.rdata;
  assign avs_waitrequest  = r.waitreq;
  assign pid_setpoint     = r.sp_out;
  assign pid_feedback     = r.y_q[31:16];
  assign feedback_display = r.disp;
  assign keypad_retain    = r.retain;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_sp_keypad_src: assert property ((r.sp_sel == 16'h0000 && r.ramp == 16'h0000 && !wr_go)
    |=> pid_setpoint == $past(r.kp)) else $error("set point not keypad");
  a_sp_ain_one: assert property ((r.sp_sel == 16'h0002 && r.ramp == 16'h0000 && !wr_go)
    |=> pid_setpoint == $past(analog_input_one)) else $error("set point not ain1");
  a_sp_term_code: assert property ((r.sp_sel == 16'h0008 && select_terminals == 3'h6
    && r.ramp == 16'h0000 && !wr_go) |=> pid_setpoint == $past(rs485_value))
    else $error("terminal code 6 not rs485");
  a_sp_active_comm: assert property ((r.sp_sel == 16'h0009 && r.ramp == 16'h0000 && !wr_go)
    |=> pid_setpoint == $past(r.act_comm)) else $error("set point not active current");
  a_kp_write_mon: assert property ((wr_go && aligned && idx == IDX_KP && r.sp_sel == 16'h0000
    && merge(r.kp) <= MAX_PCT) |=> pid_setpoint == $past(merge(r.kp)))
    else $error("monitor not updated by keypad write");
  a_ramp_step_one: assert property ((r.ramp != 16'h0000 && !wr_go)
    |=> (pid_setpoint - $past(pid_setpoint) <= 16'h0001
      || $past(pid_setpoint) - pid_setpoint <= 16'h0001)) else $error("ramp jumped");
  a_sel_refuse: assert property ((wr_go && aligned && idx == IDX_FB_SEL
    && merge(r.fb_sel) > MAX_SEL) |=> r.fb_sel == $past(r.fb_sel))
    else $error("bad feedback code accepted");
  a_fb_gain_pass: assert property ((r.tick && r.alpha == 17'h10000 && r.gain == 16'h00c8
    && fb_raw < 16'h1000) |=> pid_feedback == 16'($past(fb_raw) * 2))
    else $error("feedback gain wrong");
  a_fb_local_cur: assert property ((r.tick && r.alpha == 17'h10000 && r.gain == 16'h0064
    && r.fb_sel == 16'h0009) |=> pid_feedback == $past(local_active_current))
    else $error("feedback not local current");
  a_disp_scale: assert property ((r.range == 16'h01f4) ##1 (r.range == 16'h01f4)
    |-> feedback_display == 16'($past(pid_feedback) / 2)) else $error("display wrong");
  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus wait state wrong");
endmodule : psfs_top

// File: test/psfs_src_model.sv
// Purpose: source channels and keyboard that feed the pid conditioning block
// Assumes: channel with source code k carries k*16 plus one common offset
// Notes:   keys pass straight through, one unit per high cycle
`timescale 1ns/10ps
module psfs_src_model (
  input  wire logic [15:0] offset,
  input  wire logic        press_up,
  input  wire logic        press_down,
  output logic      [15:0] pot,
  output logic      [15:0] ain1,
  output logic      [15:0] ain2,
  output logic      [15:0] pulse,
  output logic      [15:0] rs485,
  output logic      [15:0] option,
  output logic      [15:0] local_cur,
  output logic             key_up,
  output logic             key_down
);
  // ========
  // channel levels
  // distinct level per channel, so a wrong pick always shows
  assign pot       = 16'h0010 + offset;
  assign ain1      = 16'h0020 + offset;
  assign ain2      = 16'h0030 + offset;
  assign pulse     = 16'h0050 + offset;
  assign rs485     = 16'h0060 + offset;
  assign option    = 16'h0070 + offset;
  assign local_cur = 16'h0090 + offset;
  assign key_up    = press_up;
  assign key_down  = press_down;
endmodule : psfs_src_model

// File: test/tb_psfs_top.sv
// Purpose: self-checking bench for set point / feedback selection and conditioning
// Assumes: tick shortened to 64 cycles, filter time 0 gives a pass-through filter
// Notes:   set point and feedback sampled on the falling edge but keypad-unused at a rising edge, as is bus read data; inputs change after the rising edge
`timescale 1ns/10ps
module tb_psfs_top import psfs_pkg::*;;
  localparam int TCK = 64;
  logic        ref_clk, resetn, avs_read, avs_write, avs_waitrequest, keypad_retain;
  logic        key_up, key_down, press_up, press_down;
  logic [15:0] avs_address, pot, ain1, ain2, pulse, rs485, option, local_cur;
  logic [15:0] pid_setpoint, pid_feedback, feedback_display, offset, kp;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [2:0]  select_terminals;
  int          fails, checks_done;

  psfs_src_model psfs_src_model_i (.offset(offset), .press_up(press_up),
    .press_down(press_down), .pot(pot), .ain1(ain1), .ain2(ain2), .pulse(pulse),
    .rs485(rs485), .option(option), .local_cur(local_cur), .key_up(key_up),
    .key_down(key_down));
  psfs_top #(.TICK_CYCLES(TCK)) psfs_top_i (.ref_clk(ref_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .analog_input_one(ain1), .analog_input_two(ain2), .pot_value(pot),
    .pulse_input_terminal(pulse), .rs485_value(rs485), .option_card_value(option),
    .local_active_current(local_cur), .select_terminals(select_terminals),
    .key_up(key_up), .key_down(key_down), .pid_setpoint(pid_setpoint),
    .pid_feedback(pid_feedback), .feedback_display(feedback_display),
    .keypad_retain(keypad_retain));

  // ========
  // common tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic bus(input logic wr, input logic [13:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= {idx, 2'b00};
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {16'h0000, wd};
    // hold everything until waitrequest is seen low at a rising edge
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 100) fails++;
  endtask : bus

  task automatic wr(input logic [13:0] idx, input logic [15:0] d);
    logic [31:0] v;
    bus(1'b1, idx, d, v);
  endtask : wr

  task automatic rd_chk(input string what, input logic [13:0] idx, input logic [15:0] e);
    logic [31:0] v;
    bus(1'b0, idx, 16'h0000, v);
    check(what, v, {16'h0000, e});
  endtask : rd_chk

  // expected level of a source code; code 9 differs between the two paths
  function automatic logic [15:0] exp_src(input int k, input logic fb);
    if (k == 0) return kp;
    if (k == 4) return 16'h0000;
    if (k == 9 && !fb) return 16'h0123;
    return 16'(k * 16) + offset;
  endfunction : exp_src

  // ========
  // scenarios
  task automatic t_regs();
    rd_chk("sp_sel", IDX_SP_SEL, 16'h0000);
    rd_chk("keypad", IDX_KP, 16'h01f4);
    rd_chk("ramp", IDX_RAMP, 16'h0064);
    rd_chk("fb_sel", IDX_FB_SEL, 16'h0002);
    rd_chk("filter", IDX_FILT, 16'h000a);
    rd_chk("gain", IDX_GAIN, 16'h0064);
    rd_chk("range", IDX_RANGE, 16'h03e8);
    rd_chk("unmapped", 14'h0100, 16'h0000);
    check("retain", keypad_retain, 1'b0);
  endtask : t_regs

  task automatic t_refuse();
    wr(IDX_SP_SEL, 16'h000a);
    rd_chk("sp_sel", IDX_SP_SEL, 16'h0000);
    wr(IDX_FB_SEL, 16'h000f);
    rd_chk("fb_sel", IDX_FB_SEL, 16'h0002);
    wr(IDX_KP, 16'h03e9);
    rd_chk("keypad", IDX_KP, 16'h01f4);
    wr(IDX_RAMP, 16'h1771);
    rd_chk("ramp", IDX_RAMP, 16'h0064);
  endtask : t_refuse

  task automatic t_keypad();
    wr(IDX_RAMP, 16'h0000);
    kp = 16'h0141;
    wr(IDX_KP, kp);
    @(negedge ref_clk);
    check("sp at once", pid_setpoint, kp);
    rd_chk("sp monitor", IDX_SP_MON, kp);
    wr(IDX_FB_SEL, 16'h0009);
    wr(IDX_SP_SEL, 16'h0002);
    kp = 16'h0064;
    wr(IDX_KP, kp);
    cyc(3);
    check("keypad unused", pid_setpoint, exp_src(2, 1'b0));
  endtask : t_keypad

  task automatic t_sp_src();
    wr(IDX_ACT_COMM, 16'h0123);
    select_terminals <= 3'd0;
    for (int c = 0; c < 10; c++) begin
      wr(IDX_SP_SEL, 16'(c));
      cyc(3);
      @(negedge ref_clk);
      check("sp code", pid_setpoint, exp_src(c == 8 ? 0 : c, 1'b0));
    end
    wr(IDX_SP_SEL, 16'h0008);
    for (int t = 0; t < 8; t++) begin
      // terminals move only just after a rising edge, never at the sampling negedge
      @(posedge ref_clk);
      select_terminals <= 3'(t);
      cyc(3);
      @(negedge ref_clk);
      check("sp terminals", pid_setpoint, exp_src(t, 1'b0));
    end
  endtask : t_sp_src

  task automatic t_fb_src();
    wr(IDX_FILT, 16'h0000);
    wr(IDX_SP_SEL, 16'h0009);
    for (int c = 0; c < 18; c++) begin
      // codes 10 and up walk the terminals, so the selector must say terminal code 8
      wr(IDX_FB_SEL, 16'(c < 10 ? c : 8));
      select_terminals <= (c < 10) ? 3'd0 : 3'(c - 10);
      cyc(4 * TCK);
      @(negedge ref_clk);
      check("fb code", pid_feedback, exp_src(c < 10 ? (c == 8 ? 0 : c) : c - 10, 1'b1));
    end
  endtask : t_fb_src

  task automatic t_gain();
    wr(IDX_FB_SEL, 16'h0002);
    wr(IDX_GAIN, 16'h00c8);
    cyc(4 * TCK);
    @(negedge ref_clk);
    check("fb gain", pid_feedback, 16'h0040);
    check("display full", feedback_display, 16'h0040);
    wr(IDX_RANGE, 16'h01f4);
    cyc(4);
    @(negedge ref_clk);
    check("fb range", pid_feedback, 16'h0040);
    check("display half", feedback_display, 16'h0020);
    wr(IDX_GAIN, 16'h0064);
    wr(IDX_RANGE, 16'h03e8);
  endtask : t_gain

  task automatic t_filter();
    cyc(4 * TCK);
    wr(IDX_FILT, 16'h003f);
    cyc(4 * TCK);
    offset <= 16'h0200;
    cyc(TCK + 40);
    @(negedge ref_clk);
    // coefficient 1/64: a step of 512 moves only a few units per tick
    check("fb slow", pid_feedback > 16'h0020 && pid_feedback < 16'h0064, 1'b1);
    cyc(4 * TCK);
    @(negedge ref_clk);
    check("fb settling", pid_feedback > 16'h0030 && pid_feedback < 16'h0220, 1'b1);
    wr(IDX_FILT, 16'h0000);
    offset <= 16'h0000;
  endtask : t_filter

  task automatic t_keys();
    wr(IDX_SHORTCUT, 16'h0012);
    cyc(2);
    @(negedge ref_clk);
    check("retain", keypad_retain, 1'b1);
    cyc(1);
    press_up <= 1'b1;
    cyc(5);
    press_up <= 1'b0;
    press_down <= 1'b1;
    cyc(2);
    press_down <= 1'b0;
    rd_chk("keys on", IDX_KP, kp + 16'h0003);
    wr(IDX_SHORTCUT, 16'h0000);
    press_up <= 1'b1;
    cyc(4);
    press_up <= 1'b0;
    rd_chk("keys off", IDX_KP, kp + 16'h0003);
    check("no retain", keypad_retain, 1'b0);
  endtask : t_keys

  task automatic t_ramp();
    // feedback sits on ain1, so the set point takes ain2
    wr(IDX_SP_SEL, 16'h0003);
    cyc(4);
    wr(IDX_RAMP, 16'h0001);
    offset <= 16'h0005;
    // one unit per 200 cycles at the smallest nonzero ramp time
    cyc(500);
    @(negedge ref_clk);
    check("ramp mid", pid_setpoint > 16'h0030 && pid_setpoint < 16'h0034, 1'b1);
    cyc(800);
    @(negedge ref_clk);
    check("ramp end", pid_setpoint, 16'h0035);
  endtask : t_ramp

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // ========
  // clock, watchdog, main sequence
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    cyc(60000);
    fails++;
    stop_test();
  end

  initial begin
    {resetn, avs_read, avs_write, press_up, press_down} = 5'h00;
    {avs_address, avs_writedata, offset} = 64'h0;
    {avs_byteenable, select_terminals, fails, checks_done} = 0;
    avs_byteenable = 4'hf;
    kp = 16'h01f4;
    cyc(3);
    resetn <= 1'b1;
    t_regs();
    t_refuse();
    t_keypad();
    t_sp_src();
    t_fb_src();
    t_gain();
    t_filter();
    t_keys();
    t_ramp();
    stop_test();
  end
endmodule : tb_psfs_top
